// file: pkg/dsct_defines.svh
`ifndef DSCT_DEFINES_SVH
`define DSCT_DEFINES_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define DSCT_LEVEL_W     8
`define DSCT_COUPLING_W  2
`define DSCT_SEL_W       2
`define DSCT_INPUTS      4

// ----------------------------------------------------------------------
// source selector codes (index into the comparator vector)
// ----------------------------------------------------------------------
`define DSCT_SEL_CH_ONE  2'h0
`define DSCT_SEL_CH_TWO  2'h1
`define DSCT_SEL_EXT_ONE 2'h2
`define DSCT_SEL_EXT_TWO 2'h3

// ----------------------------------------------------------------------
// slope codes and reset values
// ----------------------------------------------------------------------
`define DSCT_SLOPE_POS   1'h0
`define DSCT_SLOPE_NEG   1'h1
`define DSCT_RST_BIT     1'h0
`define DSCT_RST_SYNC    2'h0

`endif

// file: pkg/dsct_pkg.sv
`default_nettype none

`include "dsct_defines.svh"

package dsct_pkg;

  // ----------------------------------------------------------------------
  // complete state of the trigger qualifier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`DSCT_SEL_W-1:0]      sel_pri;
    logic                        slope_pri;
    logic [`DSCT_SEL_W-1:0]      sel_sec;
    logic                        slope_sec;
    logic                        primed;
    logic                        above_pri;
    logic                        above_sec;
    logic                        true_pri;
    logic                        true_sec;
    logic                        edge_pri;
    logic                        edge_sec;
    logic                        capture;
    logic [`DSCT_LEVEL_W-1:0]    level_pri;
    logic [`DSCT_LEVEL_W-1:0]    level_sec;
    logic [`DSCT_COUPLING_W-1:0] coup_pri;
    logic [`DSCT_COUPLING_W-1:0] coup_sec;
  } dsct_state_t;

endpackage

`default_nettype wire

// file: rtl/dsct_trigger.sv
`timescale 1ns/1ps
`default_nettype none

`include "dsct_defines.svh"

// Functional notes
// - positive slope: source true only while its input is above its level.
// - negative slope: source true only while its input is below its level.
// - combined mode fires capture only while both sources are true together.
// - at least one source must cross its level when capture fires.
// - a crossing qualifies only in the direction of that source's slope.
// - the capture-start output starts the primary acquisition when the condition holds.
// - combined mode takes one primary-selected and one secondary-selected source.
// - each source keeps its own level, slope and coupling setting.
// - each selector picks channel one, channel two, external one or two.
module dsct_trigger
(
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic                        combined_mode,
  input  wire logic [`DSCT_SEL_W-1:0]      sel_pri,
  input  wire logic                        slope_pri,
  input  wire logic [`DSCT_LEVEL_W-1:0]    level_pri,
  input  wire logic [`DSCT_COUPLING_W-1:0] coupling_pri,
  input  wire logic [`DSCT_INPUTS-1:0]     cmp_pri_above,
  input  wire logic [`DSCT_SEL_W-1:0]      sel_sec,
  input  wire logic                        slope_sec,
  input  wire logic [`DSCT_LEVEL_W-1:0]    level_sec,
  input  wire logic [`DSCT_COUPLING_W-1:0] coupling_sec,
  input  wire logic [`DSCT_INPUTS-1:0]     cmp_sec_above,
  output logic                             capture_start,
  output logic                             source_pri_true,
  output logic                             source_sec_true,
  output logic                             edge_pri,
  output logic                             edge_sec,
  output logic [`DSCT_LEVEL_W-1:0]         level_pri_out,
  output logic [`DSCT_LEVEL_W-1:0]         level_sec_out,
  output logic [`DSCT_COUPLING_W-1:0]      coupling_pri_out,
  output logic [`DSCT_COUPLING_W-1:0]      coupling_sec_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pick the comparator of the selected input
  function automatic logic pick_input(input logic [`DSCT_INPUTS-1:0] above,
                                      input logic [`DSCT_SEL_W-1:0]  sel);
    pick_input = above[sel];
  endfunction

  // truth of a source from its comparator and slope
  function automatic logic src_true(input logic above,
                                    input logic slope);
    if (slope == `DSCT_SLOPE_POS)
    begin
      src_true = above;
    end
    else
    begin
      src_true = ~above;
    end
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n_i;

  // async assert, two-flop synchronous release
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_reg <= `DSCT_RST_SYNC;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  assign rst_n_i = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // qualifier state
  // ----------------------------------------------------------------------
  dsct_pkg::dsct_state_t s_reg;
  dsct_pkg::dsct_state_t s_next;
  logic                  abv_pri;
  logic                  abv_sec;
  logic                  cfg_same;

  assign abv_pri  = pick_input(cmp_pri_above, sel_pri);
  assign abv_sec  = pick_input(cmp_sec_above, sel_sec);
  // a selector or slope change is not a crossing of the signal
  assign cfg_same = (sel_pri == s_reg.sel_pri) && (slope_pri == s_reg.slope_pri) &&
                    (sel_sec == s_reg.sel_sec) && (slope_sec == s_reg.slope_sec);

  // next state: truth, direction-qualified crossings, coincidence
  always_comb
  begin
    s_next           = s_reg;
    s_next.sel_pri   = sel_pri;
    s_next.slope_pri = slope_pri;
    s_next.sel_sec   = sel_sec;
    s_next.slope_sec = slope_sec;
    s_next.level_pri = level_pri;
    s_next.level_sec = level_sec;
    s_next.coup_pri  = coupling_pri;
    s_next.coup_sec  = coupling_sec;
    s_next.above_pri = abv_pri;
    s_next.above_sec = abv_sec;
    s_next.primed    = 1'h1;
    s_next.true_pri  = src_true(abv_pri, slope_pri);
    s_next.true_sec  = src_true(abv_sec, slope_sec);
    // crossing into the true side is the slope's own direction
    s_next.edge_pri  = s_reg.primed && cfg_same &&
                       (abv_pri != s_reg.above_pri) && s_next.true_pri;
    s_next.edge_sec  = s_reg.primed && cfg_same &&
                       (abv_sec != s_reg.above_sec) && s_next.true_sec;
    s_next.capture   = combined_mode &&
                       s_next.true_pri && s_next.true_sec &&
                       (s_next.edge_pri || s_next.edge_sec);
  end

  // single register bank; no edge can fire until one sample is held
  always_ff @(posedge clk_sys or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, straight from the state flops
  // ----------------------------------------------------------------------
  assign capture_start    = s_reg.capture;
  assign source_pri_true  = s_reg.true_pri;
  assign source_sec_true  = s_reg.true_sec;
  assign edge_pri         = s_reg.edge_pri;
  assign edge_sec         = s_reg.edge_sec;
  assign level_pri_out    = s_reg.level_pri;
  assign level_sec_out    = s_reg.level_sec;
  assign coupling_pri_out = s_reg.coup_pri;
  assign coupling_sec_out = s_reg.coup_sec;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking dsct_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_i);

  AST_POS_TRUE: assert property (
    s_reg.primed && $past(slope_pri) == `DSCT_SLOPE_POS |->
      source_pri_true == $past(pick_input(cmp_pri_above, sel_pri)))
    else $error("positive slope truth wrong");

  AST_NEG_TRUE: assert property (
    s_reg.primed && $past(slope_sec) == `DSCT_SLOPE_NEG |->
      source_sec_true == !$past(pick_input(cmp_sec_above, sel_sec)))
    else $error("negative slope truth wrong");

  AST_BOTH_TRUE: assert property (
    capture_start |-> source_pri_true && source_sec_true)
    else $error("capture without both sources true");

  AST_NEEDS_EDGE: assert property (
    capture_start |-> edge_pri || edge_sec)
    else $error("capture without a crossing");

  AST_EDGE_DIR: assert property (
    edge_pri |-> source_pri_true && $past(s_reg.above_pri) != s_reg.above_pri)
    else $error("crossing in wrong direction");

  AST_FIRES: assert property (
    $past(combined_mode) && source_pri_true && source_sec_true &&
      (edge_pri || edge_sec) |-> capture_start)
    else $error("qualified coincidence missed");

  AST_MODE_GATE: assert property (
    !$past(combined_mode) |-> !capture_start)
    else $error("capture outside combined mode");

  AST_OWN_SETTINGS: assert property (
    s_reg.primed |-> level_sec_out == $past(level_sec) &&
      coupling_pri_out == $past(coupling_pri))
    else $error("per-source setting not kept");

  AST_SEL_EXT_TWO: assert property (
    s_reg.primed && $past(sel_sec) == `DSCT_SEL_EXT_TWO |->
      s_reg.above_sec == $past(cmp_sec_above[3]))
    else $error("external input two not selected");

  AST_NO_EDGE_STEADY: assert property (
    s_reg.above_sec == $past(s_reg.above_sec) |-> !edge_sec)
    else $error("crossing without change");

  COV_PRI_EDGE: cover property (capture_start && edge_pri && !edge_sec);
  COV_SEC_EDGE: cover property (capture_start && edge_sec && !edge_pri);
  COV_BOTH_EDGE: cover property (capture_start && edge_pri && edge_sec);
  COV_MODE_OFF: cover property (source_pri_true && source_sec_true && edge_pri && !capture_start);

endmodule

`default_nettype wire

// file: sim/dsct_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none

`include "dsct_defines.svh"

// ----------------------------------------------------------------------
// comparator bank model, one bank per trigger source
// ----------------------------------------------------------------------
module dsct_cmp_model
(
  input  wire logic [`DSCT_INPUTS-1:0][`DSCT_LEVEL_W-1:0] samples,
  input  wire logic [`DSCT_LEVEL_W-1:0]                   level_pri,
  input  wire logic [`DSCT_LEVEL_W-1:0]                   level_sec,
  output logic [`DSCT_INPUTS-1:0]                         above_pri,
  output logic [`DSCT_INPUTS-1:0]                         above_sec
);
  // strict compare: a sample equal to the level reads as below
  always_comb
  begin
    for (int i = 0; i < `DSCT_INPUTS; i++)
    begin
      above_pri[i] = samples[i] > level_pri;
      above_sec[i] = samples[i] > level_sec;
    end
  end
endmodule

`default_nettype wire

// file: sim/dual_source_coincidence_trigger_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "dsct_defines.svh"

// ----------------------------------------------------------------------
// bench for the coincidence trigger
// ----------------------------------------------------------------------
module dual_source_coincidence_trigger_tb;
  logic        clk_sys = 1'h0;
  logic        rstn    = 1'h0;
  logic        mode    = 1'h1;
  logic        slope_p = 1'h0;
  logic        slope_s = 1'h1;
  logic [1:0]  sel_p   = 2'h0;
  logic [1:0]  sel_s   = 2'h3;
  logic [31:0] smp     = 32'h0;
  logic [3:0]  abv_p;
  logic [3:0]  abv_s;
  logic        cap, pt, st, ep, es;
  logic [7:0]  lvp, lvs;
  logic [1:0]  cpp, cps;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cycles      = 0;

  always #5 clk_sys = ~clk_sys;

  dsct_cmp_model CMP
  (
    .samples   (smp),
    .level_pri (lvp),
    .level_sec (lvs),
    .above_pri (abv_p),
    .above_sec (abv_s)
  );

  dsct_trigger DUT
  (
    .clk_sys          (clk_sys),
    .rstn             (rstn),
    .combined_mode    (mode),
    .sel_pri          (sel_p),
    .slope_pri        (slope_p),
    .level_pri        (8'h80),
    .coupling_pri     (2'h1),
    .cmp_pri_above    (abv_p),
    .sel_sec          (sel_s),
    .slope_sec        (slope_s),
    .level_sec        (8'h40),
    .coupling_sec     (2'h2),
    .cmp_sec_above    (abv_s),
    .capture_start    (cap),
    .source_pri_true  (pt),
    .source_sec_true  (st),
    .edge_pri         (ep),
    .edge_sec         (es),
    .level_pri_out    (lvp),
    .level_sec_out    (lvs),
    .coupling_pri_out (cpp),
    .coupling_sec_out (cps)
  );

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one input change, then flags {capture, pri, sec, edge pri, edge sec}
  task automatic step(input logic m, input logic [7:0] a, input logic [7:0] d,
                      input logic [4:0] exp);
    @(posedge clk_sys);
    mode <= m;
    smp  <= {d, 16'h0, a};
    @(posedge clk_sys);
    #1;
    chk("flags", {3'h0, exp}, {3'h0, cap, pt, st, ep, es});
  endtask

  // hang guard, the sequence needs well under a hundred cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("level_pri", 8'h80, lvp);
    chk("level_sec", 8'h40, lvs);
    chk("coupling", 8'h12, {2'h0, cpp, 2'h0, cps});
    step(1'b1, 8'h10, 8'h10, 5'h04);
    step(1'b1, 8'hC0, 8'h10, 5'h1E);
    step(1'b1, 8'hC0, 8'hC0, 5'h08);
    step(1'b1, 8'hC0, 8'h10, 5'h1D);
    step(1'b1, 8'h10, 8'h10, 5'h04);
    step(1'b0, 8'hC0, 8'h10, 5'h0E);
    // swap slopes; the cycle of the swap masks any crossing
    @(posedge clk_sys);
    slope_p <= 1'h1;
    slope_s <= 1'h0;
    step(1'h1, 8'h10, 8'hC0, 5'h1F);
    step(1'h1, 8'h10, 8'h10, 5'h08);
    // walk every selector code, only the chosen input above;
    // primary now negative (false), secondary positive (true)
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      sel_p <= 2'(k);
      sel_s <= 2'(k);
      smp   <= 32'h0000_00C0 << (8 * k);
      @(posedge clk_sys);
      #1;
      chk("sel_truth", 8'h01, {6'h0, pt, st});
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
